/* core/cit_pkg.sv */
// Constants and types of the timing decoder.
// Assumes every user refers to names as cit_pkg::name.
package cit_pkg;

  // ************************************************************
  // Byte lengths and clock counts
  // ************************************************************
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] CLK_ONE   = 3'h1;
  localparam logic [2:0] CLK_TWO   = 3'h2;
  localparam logic [2:0] CLK_THREE = 3'h3;
  localparam logic [2:0] CLK_FOUR  = 3'h4;
  localparam logic [2:0] CLK_FIVE  = 3'h5;
  // A taken conditional branch costs this many clocks more.
  localparam logic [2:0] CLK_TAKEN_EXTRA = 3'h1;
  localparam logic [2:0] CLK_NONE        = 3'h0;

  // ************************************************************
  // Field positions and encodings
  // ************************************************************
  localparam int BANK_LO_POS = 3;
  localparam int BANK_HI_POS = 4;
  localparam int SPC_SEL_POS = 7;
  localparam logic [4:0] PAGED_JUMP_LOW = 5'h01;
  localparam logic [4:0] PAGED_CALL_LOW = 5'h11;
  localparam logic [2:0] IND_FORM       = 3'h3;
  localparam logic [6:0] NIBBLE_XCH_HI  = 7'h6B;
  localparam logic [7:0] OP_NOP         = 8'h00;
  localparam logic [7:0] OP_SPARE       = 8'hA5;
  localparam logic [7:0] OP_BIT_CLR_JMP = 8'h10;
  localparam logic [7:0] ACC_ZERO       = 8'h00;
  localparam logic [7:0] DEC_LAST       = 8'h01;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    CND_NONE, CND_ALWAYS, CND_CARRY, CND_NO_CARRY, CND_BIT,
    CND_NO_BIT, CND_ZERO, CND_NONZERO, CND_UNEQUAL, CND_DEC_NZ
  } cit_cond_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_REL, TGT_PAGED, TGT_ABS} cit_tgt_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_EXEC = 2'h2} cit_state_t;
  typedef struct packed {
    logic       known;
    logic [1:0] len;
    logic [2:0] clk;
    cit_cond_t  cond;
    cit_tgt_t   tgt;
  } cit_dec_t;

endpackage

/* core/cit_target_if.sv */
// Interface between the decoder and its branch target calculator.
// Assumes the decoder drives the operands and reads back the target.
`timescale 1ns/10ps
`default_nettype none
interface cit_target_if;
  logic             [15:0] nextPc;
  logic             [7:0]  relOffset;
  logic             [10:0] pagedTarget;
  logic             [15:0] absoluteTarget;
  cit_pkg::cit_tgt_t       kind;
  logic             [15:0] target;

  // Calculator end and decoder end.
  modport calc (input nextPc, relOffset, pagedTarget, absoluteTarget, kind,
                output target);
  modport user (output nextPc, relOffset, pagedTarget, absoluteTarget, kind,
                input target);
endinterface
`default_nettype wire

/* core/cit_target_calc.sv */
// Branch target calculator for relative, paged and absolute operands.
// Assumes nextPc is the address of the first byte of the next instruction.
`timescale 1ns/10ps
`default_nettype none
module cit_target_calc (
  // Operands in, target out.
  cit_target_if.calc tgt
);

  // ************************************************************
  // Target selection
  // ************************************************************
  // Forms the target; with no kind, the next address.
  always_comb begin
    case (tgt.kind)
      cit_pkg::TGT_REL: begin
        tgt.target = 16'(tgt.nextPc + {{8{tgt.relOffset[7]}}, tgt.relOffset});
      end
      cit_pkg::TGT_PAGED: begin
        tgt.target = {tgt.nextPc[15:11], tgt.pagedTarget};
      end
      cit_pkg::TGT_ABS: begin
        tgt.target = tgt.absoluteTarget;
      end
      default: begin
        tgt.target = tgt.nextPc;
      end
    endcase
  end

endmodule
`default_nettype wire

/* core/cit_timing_decode.sv */
// Instruction length and clock-count decoder for the accumulator core.
// Assumes opcode, operand bytes, opcode address and the condition inputs
// are valid and stable in any cycle in which opValid is high.
//
// How it works
// - OR and XOR into A: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// - Logic op into direct byte: with A 2/2, with immediate 3/3.
// - Clear, complement, rotates and nibble swap of A: one byte, one clock.
// - Register moves 1/1, direct or immediate moves 2/2, A to indirect 1/2.
// - Direct-to-direct, direct-immediate moves and data pointer load: 3 bytes, 3 clocks.
// - Code byte reads relative to data pointer or program counter: 1 byte, 3 clocks.
// - External data moves with 8-bit or 16-bit address: 1 byte, 3 clocks.
// - Push and pop of a direct byte: 2 bytes, 2 clocks.
// - Exchanges: register 1/1, direct 2/2, indirect 1/2; nibble exchange swaps bits 3:0.
// - Carry ops 1/1; direct bit ops and bit/carry moves 2/2.
// - Carry, zero and register-decrement jumps: 2 bytes, 2 or 3 clocks.
// - Bit, compare, direct-decrement jumps: 3 bytes, 3 or 4; opcode 0x10 clears its bit on jump.
// - Compare immediate with indirect RAM and jump: 3 bytes, 4 or 5 clocks.
// - Paged call/jump and short jump 2/3, indirect jump 1/3, returns 1/5.
// - Long call and long jump: 16-bit target, 3 bytes, 4 clocks.
// - Relative offset is signed 8-bit, added to next instruction address.
// - Paged target: 11 bits inside the next instruction's 2 kB page.
// - Direct operand below 0x80 is data RAM, otherwise special register space.
// - Bank register picks one of eight; indirect uses register 0 or 1.
// - Spare opcode 0xA5 acts as no-operation: one byte, one clock.
// - Conditional branches take one clock fewer when not taken.
// - Active bank is chosen by status word bits 4 and 3.
`timescale 1ns/10ps
`default_nettype none
module cit_timing_decode (
  // Clock and reset.
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // Fetched instruction.
  input  wire  logic        opValid,
  output logic              opReady,
  input  wire  logic [7:0]  opcode,
  input  wire  logic [7:0]  operandA,
  input  wire  logic [7:0]  operandB,
  input  wire  logic [15:0] instrAddr,
  // Status word and branch condition sources.
  input  wire  logic [7:0]  programStatusWord,
  input  wire  logic        carryFlag,
  input  wire  logic [7:0]  accValue,
  input  wire  logic        testBit,
  input  wire  logic [7:0]  cmpLeft,
  input  wire  logic [7:0]  cmpRight,
  input  wire  logic [7:0]  decSource,
  // Timing results.
  output logic              busy,
  output logic              instrDone,
  output logic              known,
  output logic [1:0]        instLength,
  output logic [2:0]        clockCount,
  output logic              branchTaken,
  output logic [15:0]       branchTarget,
  // Operand decode results.
  output logic [7:0]        directAddr,
  output logic              directUpper,
  output logic [7:0]        bankRegAddr,
  output logic [7:0]        indirectPtrAddr,
  output logic              nibbleOnly,
  output logic              clearTestedBit,
  output logic              isNop
);

  // ************************************************************
  // Table figures
  // ************************************************************
  // Local short names.
  localparam logic [1:0] L1 = cit_pkg::LEN_ONE;
  localparam logic [1:0] L2 = cit_pkg::LEN_TWO;
  localparam logic [1:0] L3 = cit_pkg::LEN_THREE;
  localparam logic [2:0] K1 = cit_pkg::CLK_ONE;
  localparam logic [2:0] K2 = cit_pkg::CLK_TWO;
  localparam logic [2:0] K3 = cit_pkg::CLK_THREE;
  localparam logic [2:0] K4 = cit_pkg::CLK_FOUR;
  localparam logic [2:0] K5 = cit_pkg::CLK_FIVE;

  // ************************************************************
  // Functions
  // ************************************************************
  // Entry for a non-branching opcode.
  function automatic cit_pkg::cit_dec_t mk(input logic [1:0] l,
                                           input logic [2:0] k);
    cit_pkg::cit_dec_t d;
    d.known = 1'b1;
    d.len   = l;
    d.clk   = k;
    d.cond  = cit_pkg::CND_NONE;
    d.tgt   = cit_pkg::TGT_NONE;
    return d;
  endfunction

  // Entry for a branching opcode.
  function automatic cit_pkg::cit_dec_t mkb(input logic [1:0] l,
                                            input logic [2:0] k,
                                            input cit_pkg::cit_cond_t c,
                                            input cit_pkg::cit_tgt_t t);
    cit_pkg::cit_dec_t d;
    d      = mk(l, k);
    d.cond = c;
    d.tgt  = t;
    return d;
  endfunction

  // True for a conditional branch.
  function automatic logic isCond(input cit_pkg::cit_cond_t c);
    return (c != cit_pkg::CND_NONE) && (c != cit_pkg::CND_ALWAYS);
  endfunction

  // Decodes length, not-taken clock count, condition and target kind.
  // Arithmetic opcodes are outside this block and come back unknown.
  function automatic cit_pkg::cit_dec_t decodeOp(input logic [7:0] op);
    cit_pkg::cit_dec_t d;
    d       = mk(L1, K1);
    d.known = 1'b0;
    if (op[4:0] == cit_pkg::PAGED_JUMP_LOW) begin
      d = mkb(L2, K3, cit_pkg::CND_ALWAYS, cit_pkg::TGT_PAGED);
    end else if (op[4:0] == cit_pkg::PAGED_CALL_LOW) begin
      d = mkb(L2, K3, cit_pkg::CND_ALWAYS, cit_pkg::TGT_PAGED);
    end else if (op[3]) begin
      // Bank register column.
      case (op[7:4])
        4'h4, 4'h5, 4'h6: d = mk(L1, K1);
        4'hE, 4'hF: d = mk(L1, K1);
        4'hC: d = mk(L1, K1);
        4'h7, 4'h8, 4'hA: d = mk(L2, K2);
        4'hB: d = mkb(L3, K3, cit_pkg::CND_UNEQUAL, cit_pkg::TGT_REL);
        4'hD: d = mkb(L2, K2, cit_pkg::CND_DEC_NZ, cit_pkg::TGT_REL);
        default: d.known = 1'b0;
      endcase
    end else if (op[3:1] == cit_pkg::IND_FORM) begin
      // Indirect register column.
      case (op[7:4])
        4'h4, 4'h5, 4'h6: d = mk(L1, K2);
        4'hC, 4'hD: d = mk(L1, K2);
        4'hE, 4'hF: d = mk(L1, K2);
        4'h7, 4'h8, 4'hA: d = mk(L2, K2);
        4'hB: d = mkb(L3, K4, cit_pkg::CND_UNEQUAL, cit_pkg::TGT_REL);
        default: d.known = 1'b0;
      endcase
    end else begin
      case (op)
        cit_pkg::OP_NOP, cit_pkg::OP_SPARE: d = mk(L1, K1);
        8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4: d = mk(L1, K1);
        8'hB3, 8'hC3, 8'hD3: d = mk(L1, K1);
        8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2: d = mk(L2, K2);
        8'hB0, 8'hB2, 8'hC2, 8'hD2: d = mk(L2, K2);
        8'h42, 8'h52, 8'h62: d = mk(L2, K2);
        8'h43, 8'h53, 8'h63: d = mk(L3, K3);
        8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65: d = mk(L2, K2);
        8'h74, 8'hE5, 8'hF5: d = mk(L2, K2);
        8'h75, 8'h85, 8'h90: d = mk(L3, K3);
        8'h83, 8'h93: d = mk(L1, K3);
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: d = mk(L1, K3);
        8'hC0, 8'hD0: d = mk(L2, K2);
        8'hC5: d = mk(L2, K2);
        8'h40: d = mkb(L2, K2, cit_pkg::CND_CARRY, cit_pkg::TGT_REL);
        8'h50: d = mkb(L2, K2, cit_pkg::CND_NO_CARRY, cit_pkg::TGT_REL);
        8'h60: d = mkb(L2, K2, cit_pkg::CND_ZERO, cit_pkg::TGT_REL);
        8'h70: d = mkb(L2, K2, cit_pkg::CND_NONZERO, cit_pkg::TGT_REL);
        8'h10, 8'h20: d = mkb(L3, K3, cit_pkg::CND_BIT, cit_pkg::TGT_REL);
        8'h30: d = mkb(L3, K3, cit_pkg::CND_NO_BIT, cit_pkg::TGT_REL);
        8'hB4, 8'hB5: d = mkb(L3, K3, cit_pkg::CND_UNEQUAL, cit_pkg::TGT_REL);
        8'hD5: d = mkb(L3, K3, cit_pkg::CND_DEC_NZ, cit_pkg::TGT_REL);
        8'h80: d = mkb(L2, K3, cit_pkg::CND_ALWAYS, cit_pkg::TGT_REL);
        8'h73: d = mkb(L1, K3, cit_pkg::CND_ALWAYS, cit_pkg::TGT_NONE);
        8'h22, 8'h32: d = mkb(L1, K5, cit_pkg::CND_ALWAYS, cit_pkg::TGT_NONE);
        8'h02, 8'h12: d = mkb(L3, K4, cit_pkg::CND_ALWAYS, cit_pkg::TGT_ABS);
        default: d.known = 1'b0;
      endcase
    end
    return d;
  endfunction

  // Evaluates a branch condition.
  function automatic logic condMet(input cit_pkg::cit_cond_t c);
    logic m;
    m = 1'b0;
    case (c)
      cit_pkg::CND_ALWAYS:   m = 1'b1;
      cit_pkg::CND_CARRY:    m = carryFlag;
      cit_pkg::CND_NO_CARRY: m = !carryFlag;
      cit_pkg::CND_BIT:      m = testBit;
      cit_pkg::CND_NO_BIT:   m = !testBit;
      cit_pkg::CND_ZERO:     m = (accValue == cit_pkg::ACC_ZERO);
      cit_pkg::CND_NONZERO:  m = (accValue != cit_pkg::ACC_ZERO);
      cit_pkg::CND_UNEQUAL:  m = (cmpLeft != cmpRight);
      cit_pkg::CND_DEC_NZ:   m = (decSource != cit_pkg::DEC_LAST);
      default:               m = 1'b0;
    endcase
    return m;
  endfunction

  // ************************************************************
  // Decode of the offered opcode
  // ************************************************************
  cit_pkg::cit_dec_t   dec;
  logic                taken;
  logic                accept;
  logic [1:0]          bank;
  logic [15:0]         nextPc;
  cit_target_if        tgtBus ();

  // Table lookup and condition check.
  always_comb begin
    dec   = decodeOp(opcode);
    taken = condMet(dec.cond);
  end

  // Bank and next-instruction address.
  assign bank   = {programStatusWord[cit_pkg::BANK_HI_POS],
                   programStatusWord[cit_pkg::BANK_LO_POS]};
  assign nextPc = 16'(instrAddr + 16'(dec.len));

  // Operands for the target calculator; a 3-byte branch keeps its offset last.
  assign tgtBus.nextPc         = nextPc;
  assign tgtBus.relOffset      = (dec.len == L3) ? operandB : operandA;
  assign tgtBus.pagedTarget    = {opcode[7:5], operandA};
  assign tgtBus.absoluteTarget = {operandA, operandB};
  assign tgtBus.kind           = taken ? dec.tgt : cit_pkg::TGT_NONE;

  cit_target_calc u_target (
    .tgt (tgtBus)
  );

  // ************************************************************
  // Clock counter and result registers
  // ************************************************************
  cit_pkg::cit_state_t state_q;
  cit_pkg::cit_state_t state_d;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  logic                known_q;
  logic                known_d;
  logic [1:0]          len_q;
  logic [1:0]          len_d;
  logic [2:0]          clk_q;
  logic [2:0]          clk_d;
  logic                taken_q;
  logic                taken_d;
  logic [15:0]         target_q;
  logic [15:0]         target_d;
  logic [7:0]          direct_q;
  logic [7:0]          direct_d;
  logic                spc_q;
  logic                spc_d;
  logic [7:0]          bankReg_q;
  logic [7:0]          bankReg_d;
  logic [7:0]          indPtr_q;
  logic [7:0]          indPtr_d;
  logic                nibble_q;
  logic                nibble_d;
  logic                clrBit_q;
  logic                clrBit_d;
  logic                nop_q;
  logic                nop_d;

  // Handshake: a new opcode is taken when idle or in the last clock.
  assign instrDone = (state_q == cit_pkg::ST_EXEC) && (cnt_q == clk_q);
  assign opReady   = (state_q == cit_pkg::ST_IDLE) || instrDone;
  assign accept    = opValid && opReady;
  assign busy      = (state_q == cit_pkg::ST_EXEC);

  // Next values: count clocks, latch a new opcode.
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    known_d   = known_q;
    len_d     = len_q;
    clk_d     = clk_q;
    taken_d   = taken_q;
    target_d  = target_q;
    direct_d  = direct_q;
    spc_d     = spc_q;
    bankReg_d = bankReg_q;
    indPtr_d  = indPtr_q;
    nibble_d  = nibble_q;
    clrBit_d  = clrBit_q;
    nop_d     = nop_q;
    case (state_q)
      cit_pkg::ST_IDLE: begin
        state_d = cit_pkg::ST_IDLE;
      end
      cit_pkg::ST_EXEC: begin
        if (instrDone) begin
          state_d = cit_pkg::ST_IDLE;
        end else begin
          cnt_d = 3'(cnt_q + K1);
        end
      end
      default: begin
        state_d = cit_pkg::ST_IDLE;
      end
    endcase
    if (accept) begin
      state_d   = cit_pkg::ST_EXEC;
      cnt_d     = K1;
      known_d   = dec.known;
      len_d     = dec.len;
      clk_d     = 3'(dec.clk + ((isCond(dec.cond) && taken) ?
                   cit_pkg::CLK_TAKEN_EXTRA : cit_pkg::CLK_NONE));
      taken_d   = taken;
      target_d  = tgtBus.target;
      direct_d  = operandA;
      spc_d     = operandA[cit_pkg::SPC_SEL_POS];
      bankReg_d = {3'h0, bank, opcode[2:0]};
      indPtr_d  = {3'h0, bank, 2'h0, opcode[0]};
      nibble_d  = (opcode[7:1] == cit_pkg::NIBBLE_XCH_HI);
      clrBit_d  = (opcode == cit_pkg::OP_BIT_CLR_JMP) && taken;
      nop_d     = (opcode == cit_pkg::OP_NOP) || (opcode == cit_pkg::OP_SPARE);
    end
  end

  // Registers with synchronous reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= cit_pkg::ST_IDLE;
      cnt_q     <= '0;
      known_q   <= 1'b0;
      len_q     <= '0;
      clk_q     <= '0;
      taken_q   <= 1'b0;
      target_q  <= '0;
      direct_q  <= '0;
      spc_q     <= 1'b0;
      bankReg_q <= '0;
      indPtr_q  <= '0;
      nibble_q  <= 1'b0;
      clrBit_q  <= 1'b0;
      nop_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      known_q   <= known_d;
      len_q     <= len_d;
      clk_q     <= clk_d;
      taken_q   <= taken_d;
      target_q  <= target_d;
      direct_q  <= direct_d;
      spc_q     <= spc_d;
      bankReg_q <= bankReg_d;
      indPtr_q  <= indPtr_d;
      nibble_q  <= nibble_d;
      clrBit_q  <= clrBit_d;
      nop_q     <= nop_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Results stay on the flops until reset or the next accepted opcode.
  assign known           = known_q;
  assign instLength      = len_q;
  assign clockCount      = clk_q;
  assign branchTaken     = taken_q;
  assign branchTarget    = target_q;
  assign directAddr      = direct_q;
  assign directUpper     = spc_q;
  assign bankRegAddr     = bankReg_q;
  assign indirectPtrAddr = indPtr_q;
  assign nibbleOnly      = nibble_q;
  assign clearTestedBit  = clrBit_q;
  assign isNop           = nop_q;

endmodule
`default_nettype wire

/* tb/cit_code_mem.sv */
// Code memory: opcode and operand bytes for the decoder.
// Assumes the fetch address points at an opcode.
`timescale 1ns/10ps
`default_nettype none
module cit_code_mem (
  // Fetch address and the three bytes found there.
  input  wire logic [15:0] addr,
  output logic      [7:0]  b0,
  output logic      [7:0]  b1,
  output logic      [7:0]  b2
);
  logic [7:0] mem [0:1023];
  // Opcodes at 4*n; scrambled operands give both offset signs.
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = (i % 4 == 0) ? 8'(i / 4) : 8'(i * 157 + 53);
    end
  end
  // Byte lanes follow the fetch address.
  assign b0 = mem[addr[9:0]];
  assign b1 = mem[10'(addr[9:0] + 10'h001)];
  assign b2 = mem[10'(addr[9:0] + 10'h002)];
endmodule
`default_nettype wire

/* tb/cit_timing_decode_monitor.sv */
// Port-level timing and operand checks.
// Assumes it is bound to cit_timing_decode and sees one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cit_timing_decode_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Request side.
  input wire logic        opValid,
  input wire logic        opReady,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operandA,
  input wire logic [7:0]  operandB,
  input wire logic [15:0] instrAddr,
  input wire logic [7:0]  programStatusWord,
  input wire logic        carryFlag,
  // Results.
  input wire logic        busy,
  input wire logic        instrDone,
  input wire logic [1:0]  instLength,
  input wire logic [2:0]  clockCount,
  input wire logic [15:0] branchTarget,
  input wire logic [7:0]  bankRegAddr,
  input wire logic        directUpper,
  input wire logic        isNop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] cntQ, cntD;
  // Clocks since the accepting edge.
  always_comb begin
    cntD = cntQ;
    if (opValid && opReady) cntD = 3'h1;
    else if (busy) cntD = cntQ + 3'h1;
  end
  // Registers the count.
  always_ff @(posedge clk) begin
    cntQ <= sys_rst ? 3'h0 : cntD;
  end
  sequence s_take;
    opValid && opReady;
  endsequence
  sequence s_takeOp(logic [7:0] op);
    opValid && opReady && opcode == op;
  endsequence
  property p_takeBusy;
    s_take |=> busy;
  endproperty
  a_takeBusy: assert property (p_takeBusy) else $error("busy missing after accept");
  property p_doneCount;
    instrDone |-> cntQ == clockCount;
  endproperty
  a_doneCount: assert property (p_doneCount) else $error("done off clock count");
  property p_refuse;
    busy && !instrDone |-> !opReady;
  endproperty
  a_refuse: assert property (p_refuse) else $error("ready while counting");
  property p_spare;
    s_takeOp(cit_pkg::OP_SPARE) |=> isNop && instLength == cit_pkg::LEN_ONE
      && clockCount == cit_pkg::CLK_ONE;
  endproperty
  a_spare: assert property (p_spare) else $error("spare opcode timing");
  property p_long;
    s_takeOp(8'h02) |=> instLength == cit_pkg::LEN_THREE && clockCount == cit_pkg::CLK_FOUR
      && branchTarget == {$past(operandA), $past(operandB)};
  endproperty
  a_long: assert property (p_long) else $error("long jump wrong");
  property p_short;
    s_takeOp(8'h80) |=> branchTarget == $past(instrAddr) + 16'h0002
      + {{8{$past(operandA[7])}}, $past(operandA)};
  endproperty
  a_short: assert property (p_short) else $error("short jump target");
  property p_carryJump;
    s_takeOp(8'h40) |=> clockCount == ($past(carryFlag) ? cit_pkg::CLK_THREE : cit_pkg::CLK_TWO);
  endproperty
  a_carryJump: assert property (p_carryJump) else $error("carry jump clocks");
  property p_bank;
    s_take |=> bankRegAddr == {3'h0, $past(programStatusWord[4:3]), $past(opcode[2:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank register address");
  property p_spc;
    s_take |=> directUpper == $past(operandA[7]);
  endproperty
  a_spc: assert property (p_spc) else $error("direct space select");
endmodule
`default_nettype wire

/* tb/cit_timing_decode_tb_top.sv */
// Bench: every opcode against a reference table.
// Assumes the code memory model holds opcode n at address 4*n.
`timescale 1ns/10ps
`default_nettype none
module cit_timing_decode_tb_top;
  typedef struct {int l; int c; logic k; logic t; logic [15:0] g; logic [7:0] o, p, a;} cit_exp_t;
  logic        clk = 1'b0, sysRst = 1'b1, opValid = 1'b0, carryFlag = 1'b0, testBit = 1'b0;
  logic [15:0] instrAddr = 16'h0000;
  logic [7:0]  programStatusWord = 8'h00, accValue = 8'h00, cmpLeft = 8'h00;
  logic [7:0]  cmpRight = 8'h00, decSource = 8'h00, opcode, operandA, operandB;
  logic        opReady, busy, instrDone, known, branchTaken, directUpper;
  logic        nibbleOnly, clearTestedBit, isNop, b2b;
  logic [1:0]  instLength;
  logic [2:0]  clockCount;
  logic [15:0] branchTarget;
  logic [7:0]  directAddr, bankRegAddr, indirectPtrAddr;
  logic [31:0] rs = 32'h3c5e_5543;
  int          nFail = 0, checkCount = 0, cyc = 0;
  cit_exp_t    nx, cu;
  cit_code_mem cm (.addr(instrAddr), .b0(opcode), .b1(operandA), .b2(operandB));
  cit_timing_decode uut (.clk, .sys_rst(sysRst), .opValid, .opReady, .opcode, .operandA,
    .operandB, .instrAddr, .programStatusWord, .carryFlag, .accValue, .testBit, .cmpLeft,
    .cmpRight, .decSource, .busy, .instrDone, .known, .instLength, .clockCount, .branchTaken,
    .branchTarget, .directAddr, .directUpper, .bankRegAddr, .indirectPtrAddr, .nibbleOnly,
    .clearTestedBit, .isNop);
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nFail++;
      stopTest();
    end
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Length and not-taken clocks as nibbles; zero if unknown.
  function automatic logic [7:0] lc(input logic [7:0] o);
    casez (o)
      8'h00, 8'hA5, 8'hB3, 8'hC3, 8'hD3: return 8'h11;
      8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4: return 8'h11;
      8'h?1, 8'h80: return 8'h23;
      8'h02, 8'h12: return 8'h34;
      8'h22, 8'h32: return 8'h15;
      8'h73, 8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: return 8'h13;
      8'h10, 8'h20, 8'h30, 8'hD5, 8'hB4, 8'hB5, 8'b1011_1???: return 8'h33;
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90: return 8'h33;
      8'hB6, 8'hB7: return 8'h34;
      8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67, 8'hC6, 8'hC7: return 8'h12;
      8'hD6, 8'hD7, 8'hE6, 8'hE7, 8'hF6, 8'hF7: return 8'h12;
      8'h0?, 8'h1?, 8'h2?, 8'h3?, 8'h84, 8'b1001_01??, 8'b1001_1???, 8'hA3, 8'hA4, 8'hD4: return 8'h00;
      8'b010?_1???, 8'b0110_1???, 8'b1100_1???, 8'b111?_1???: return 8'h11;
      default: return 8'h22;
    endcase
  endfunction
  // Offers the opcode at address ix with random conditions; predicts results.
  task automatic offer(input logic [9:0] ix);
    logic [31:0] r;
    logic [7:0]  v, rl;
    logic        cd;
    r = rnd();
    nx.o = cm.mem[ix];
    nx.a = cm.mem[ix + 10'h001];
    nx.p = r[7:0];
    v = lc(nx.o);
    cd = 1'b1;
    casez (nx.o)
      8'h40: nx.t = r[8];
      8'h50: nx.t = !r[8];
      8'h60: nx.t = r[9] || r[17:10] == 8'h00;
      8'h70: nx.t = !(r[9] || r[17:10] == 8'h00);
      8'h10, 8'h20: nx.t = r[18];
      8'h30: nx.t = !r[18];
      8'b1011_01??, 8'b1011_1???: nx.t = !r[27] && r[26:19] != r[7:0];
      8'hD5, 8'b1101_1???: nx.t = !r[28] && r[15:8] != 8'h01;
      8'h?1, 8'h02, 8'h12, 8'h22, 8'h32, 8'h73, 8'h80: begin
        nx.t = 1'b1;
        cd = 1'b0;
      end
      default: begin
        nx.t = 1'b0;
        cd = 1'b0;
      end
    endcase
    nx.k = v != 8'h00;
    nx.l = nx.k ? v[7:4] : 1;
    nx.c = (nx.k ? v[3:0] : 1) + (cd && nx.t);
    rl = nx.l == 2 ? nx.a : cm.mem[ix + 10'h002];
    nx.g = {r[31:26], ix} + 16'(nx.l);
    if (nx.t && nx.o[3:0] == 4'h1) nx.g = {nx.g[15:11], nx.o[7:5], nx.a};
    else if (nx.t && !cd && nx.l == 3) nx.g = {nx.a, rl};
    else if (nx.t && (cd || nx.o == 8'h80)) nx.g = nx.g + {{8{rl[7]}}, rl};
    instrAddr <= {r[31:26], ix};
    programStatusWord <= r[7:0];
    carryFlag <= r[8];
    accValue <= r[9] ? 8'h00 : r[17:10];
    testBit <= r[18];
    cmpLeft <= r[26:19];
    cmpRight <= r[27] ? r[26:19] : r[7:0];
    decSource <= r[28] ? 8'h01 : r[15:8];
    opValid <= 1'b1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Compares every result but busy in the last clock of an instruction.
  task automatic check(input cit_exp_t e);
    chk("done", instrDone, 1'b1);
    chk("known", known, e.k);
    chk("length", instLength, 16'(e.l));
    chk("clocks", clockCount, 16'(e.c));
    chk("taken", branchTaken, e.t);
    chk("target", branchTarget, e.g);
    chk("bank", bankRegAddr, {3'h0, e.p[4:3], e.o[2:0]});
    chk("pointer", indirectPtrAddr, {3'h0, e.p[4:3], 2'h0, e.o[0]});
    chk("direct", {directUpper, directAddr}, {e.a[7], e.a});
    chk("nop", isNop, e.o == 8'h00 || e.o == 8'hA5);
    chk("nibble", nibbleOnly, e.o[7:1] == 7'h6B);
    chk("clearbit", clearTestedBit, e.o == 8'h10 && e.t);
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Opcode sweep with random back-to-back issue, then a reset mid-instruction.
  initial begin
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    offer(10'h000);
    for (int t = 1; t <= 512; t++) begin
      @(posedge clk);
      cu = nx;
      b2b = rs[7];
      if (!(b2b && cu.c == 1)) opValid <= 1'b0;
      repeat (cu.c - 1) @(posedge clk);
      if (b2b) offer(10'(t * 4));
      @(negedge clk);
      check(cu);
      if (!b2b) begin
        @(posedge clk);
        offer(10'(t * 4));
      end
    end
    $display("opcode sweep finished");
    @(posedge clk);
    offer(10'h088);
    repeat (3) @(posedge clk);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    opValid <= 1'b0;
    @(negedge clk);
    chk("rst busy", {busy, opReady, instrDone}, 3'h2);
    chk("rst length", {instLength, clockCount}, 5'h00);
    $display("mid-run reset finished");
    stopTest();
  end
endmodule
bind cit_timing_decode cit_timing_decode_monitor mon (.clk, .sys_rst, .opValid, .opReady,
  .opcode, .operandA, .operandB, .instrAddr, .programStatusWord, .carryFlag, .busy, .instrDone,
  .instLength, .clockCount, .branchTarget, .bankRegAddr, .directUpper, .isNop);
`default_nettype wire
